// ===== rtl/sdac_defines.svh
// Register map, field positions, reset values and timing figures
`ifndef SDAC_DEFINES_SVH
`define SDAC_DEFINES_SVH

`define SDAC_ADDR_MODE1 8'h01
`define SDAC_ADDR_MODE2 8'h02
`define SDAC_ADDR_STAT 8'h03

`define SDAC_MODE1_RST 8'h00
`define SDAC_MODE2_RST 8'h80

`define SDAC_M1_SPEED_LSB 0
`define SDAC_M1_DEEM_LSB 2
`define SDAC_M2_FMT_LSB 0
`define SDAC_M2_TRANS_BIT 4
`define SDAC_M2_CPEN_BIT 6
`define SDAC_M2_PDN_BIT 7

`define SDAC_ST_STATE_LSB 0
`define SDAC_ST_SPEED_LSB 3
`define SDAC_ST_RATIO_BIT 5
`define SDAC_ST_CPMODE_BIT 6

`define SDAC_CLK_HZ 10000000
`define SDAC_PWRUP_US 50
`define SDAC_PWRUP_CYC ((`SDAC_CLK_HZ / 1000000) * `SDAC_PWRUP_US)

`define SDAC_WIN_FRAMES 512
`define SDAC_CLAMP_FRAMES 1000
`define SDAC_RAMP_FRAMES 10000

`define SDAC_SS_MIN_HZ 4000
`define SDAC_SS_MAX_HZ 50000
`define SDAC_DS_MIN_HZ 84000
`define SDAC_DS_MAX_HZ 100000
`define SDAC_QS_MIN_HZ 170000
`define SDAC_QS_MAX_HZ 200000

`endif

// ===== rtl/sdac_pkg.sv
// Shared types of the converter front end
package sdac_pkg;

    typedef enum logic [2:0] {
        PWR_WAIT = 3'h0,
        PWR_UP = 3'h1,
        PWR_CLAMP = 3'h3,
        PWR_RAMP = 3'h2,
        PWR_RUN = 3'h6,
        PWR_STBY = 3'h4
    } sdac_pwr_t;

    typedef enum logic [1:0] {
        SPD_NONE = 2'h0,
        SPD_SINGLE = 2'h1,
        SPD_DOUBLE = 2'h2,
        SPD_QUAD = 2'h3
    } sdac_speed_t;

    typedef enum logic [2:0] {
        FMT_STD = 3'h0,
        FMT_LJ = 3'h1,
        FMT_RJ24 = 3'h2,
        FMT_RJ16 = 3'h3,
        FMT_RJ20 = 3'h4,
        FMT_RJ18 = 3'h5
    } sdac_fmt_t;

    typedef enum logic [1:0] {
        DEM_OFF = 2'h0,
        DEM_32 = 2'h1,
        DEM_441 = 2'h2,
        DEM_48 = 2'h3
    } sdac_deem_t;

endpackage : sdac_pkg

// ===== rtl/sdac_link_if.sv
// Events and samples passed from the serial receiver to the core
`timescale 1ns/100ps
`default_nettype none
interface sdac_link_if;
    logic mck_rise;
    logic frm_rise;
    logic sample_valid;
    logic [23:0] left;
    logic [23:0] right;
    sdac_pkg::sdac_fmt_t fmt;

    modport rx (
        output mck_rise,
        output frm_rise,
        output sample_valid,
        output left,
        output right,
        input fmt
    );

    modport core (
        input mck_rise,
        input frm_rise,
        input sample_valid,
        input left,
        input right,
        output fmt
    );
endinterface : sdac_link_if
`default_nettype wire

// ===== rtl/sdac_link_rx.sv
// Serial sample receiver: pin synchronisers, edge detection, word assembly
`timescale 1ns/100ps
`default_nettype none
module sdac_link_rx (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic master_clock_i,
    input wire logic frame_clock_i,
    input wire logic bit_clock_i,
    input wire logic serial_sample_in_i,
    sdac_link_if.rx lnk
);

    typedef struct packed {
        logic [1:0] mck_s;
        logic mck_d;
        logic [1:0] frm_s;
        logic frm_d;
        logic [1:0] bck_s;
        logic bck_d;
        logic [1:0] dat_s;
        logic [5:0] bit_cnt;
        logic [23:0] msb_word;
        logic [23:0] rj_word;
        logic [23:0] left;
        logic [23:0] right;
        logic mck_rise;
        logic frm_rise;
        logic valid;
    } sdac_rx_t;

    sdac_rx_t s;
    sdac_rx_t next_s;

    // Pick the channel word out of the two assembly registers
    function automatic logic [23:0] pick_word(input sdac_pkg::sdac_fmt_t f,
                                              input logic [23:0] msb,
                                              input logic [23:0] rj);
        case (f)
            sdac_pkg::FMT_RJ24: pick_word = rj;
            sdac_pkg::FMT_RJ20: pick_word = {rj[19:0], 4'h0};
            sdac_pkg::FMT_RJ18: pick_word = {rj[17:0], 6'h00};
            sdac_pkg::FMT_RJ16: pick_word = {rj[15:0], 8'h00};
            default: pick_word = msb;
        endcase
    endfunction : pick_word

    always_comb begin
        logic [5:0] pos;
        logic left_done;
        pos = 6'h00;
        left_done = 1'b0;
        next_s = s;
        next_s.mck_s = {s.mck_s[0], master_clock_i};
        next_s.frm_s = {s.frm_s[0], frame_clock_i};
        next_s.bck_s = {s.bck_s[0], bit_clock_i};
        next_s.dat_s = {s.dat_s[0], serial_sample_in_i};
        next_s.mck_d = s.mck_s[1];
        next_s.frm_d = s.frm_s[1];
        next_s.bck_d = s.bck_s[1];
        next_s.mck_rise = s.mck_s[1] & ~s.mck_d;
        next_s.frm_rise = s.frm_s[1] & ~s.frm_d;
        next_s.valid = 1'b0;
        if (s.frm_s[1] != s.frm_d) begin
            // Standard stereo carries left while the frame clock is low
            left_done = (lnk.fmt == sdac_pkg::FMT_STD) ? ~s.frm_d : s.frm_d;
            if (left_done) begin
                next_s.left = pick_word(lnk.fmt, s.msb_word, s.rj_word);
            end else begin
                next_s.right = pick_word(lnk.fmt, s.msb_word, s.rj_word);
                next_s.valid = 1'b1;
            end
            next_s.bit_cnt = 6'h00;
            next_s.msb_word = 24'h000000;
        end
        // Data is taken on the bit clock rising edge only
        if (s.bck_s[1] & ~s.bck_d) begin
            pos = next_s.bit_cnt;
            if (lnk.fmt == sdac_pkg::FMT_STD) begin
                pos = next_s.bit_cnt - 6'h01;
            end
            if (pos < 6'h18) begin
                next_s.msb_word[5'h17 - pos[4:0]] = s.dat_s[1];
            end
            next_s.rj_word = {s.rj_word[22:0], s.dat_s[1]};
            if (next_s.bit_cnt != 6'h3f) begin
                next_s.bit_cnt = next_s.bit_cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign lnk.mck_rise = s.mck_rise;
    assign lnk.frm_rise = s.frm_rise;
    assign lnk.sample_valid = s.valid;
    assign lnk.left = s.left;
    assign lnk.right = s.right;

endmodule : sdac_link_rx
`default_nettype wire

// ===== rtl/sdac_front.sv
// Converter front end: clock checks, format, de-emphasis, power-up sequence
`timescale 1ns/100ps
`default_nettype none
`include "sdac_defines.svh"

module sdac_front #(
    parameter int P_SS_LO = `SDAC_CLK_HZ / `SDAC_SS_MAX_HZ,
    parameter int P_SS_HI = `SDAC_CLK_HZ / `SDAC_SS_MIN_HZ,
    parameter int P_DS_LO = `SDAC_CLK_HZ / `SDAC_DS_MAX_HZ,
    parameter int P_DS_HI = `SDAC_CLK_HZ / `SDAC_DS_MIN_HZ,
    parameter int P_QS_LO = `SDAC_CLK_HZ / `SDAC_QS_MAX_HZ,
    parameter int P_QS_HI = `SDAC_CLK_HZ / `SDAC_QS_MIN_HZ,
    parameter int P_WIN_FRAMES = `SDAC_WIN_FRAMES,
    parameter int P_CLAMP_FRAMES = `SDAC_CLAMP_FRAMES,
    parameter int P_RAMP_FRAMES = `SDAC_RAMP_FRAMES,
    parameter int P_PWRUP_CYC = `SDAC_PWRUP_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic master_clock_i,
    input wire logic frame_clock_i,
    input wire logic bit_clock_i,
    input wire logic serial_sample_in_i,
    input wire logic format_sel_bit0_i,
    input wire logic format_sel_bit1_i,
    input wire logic deemph_pin_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic quiescent_ref_o,
    output logic bias_node_tie_o,
    output logic out_clamp_o,
    output logic out_ramp_o,
    output logic audio_run_o,
    output logic mute_o,
    output logic [1:0] speed_o,
    output logic [2:0] format_o,
    output logic [1:0] deemph_o,
    output logic [23:0] sample_left_o,
    output logic [23:0] sample_right_o,
    output logic sample_valid_o
);

    if (P_SS_HI > 4095 || P_SS_LO <= P_DS_HI || P_DS_LO <= P_QS_HI || P_QS_LO < 1) begin : g_bad_speed
        $error("speed period bounds do not fit the period counter");
    end
    if (P_WIN_FRAMES < 1 || P_WIN_FRAMES * 4 > 16383) begin : g_bad_win
        $error("frame window does not fit the frame counter");
    end
    if (P_CLAMP_FRAMES < 1 || P_CLAMP_FRAMES > 16383 || P_RAMP_FRAMES < 1 || P_RAMP_FRAMES > 16383) begin : g_bad_ramp
        $error("transient counts do not fit the frame counter");
    end
    if (P_PWRUP_CYC < 1 || P_PWRUP_CYC > 1023) begin : g_bad_pwrup
        $error("power-up count does not fit the cycle counter");
    end

    localparam logic [11:0] SS_LO = 12'(P_SS_LO);
    localparam logic [11:0] SS_HI = 12'(P_SS_HI);
    localparam logic [11:0] DS_LO = 12'(P_DS_LO);
    localparam logic [11:0] DS_HI = 12'(P_DS_HI);
    localparam logic [11:0] QS_LO = 12'(P_QS_LO);
    localparam logic [11:0] QS_HI = 12'(P_QS_HI);
    localparam logic [13:0] WIN_FRAMES = 14'(P_WIN_FRAMES);
    localparam logic [13:0] CLAMP_FRAMES = 14'(P_CLAMP_FRAMES);
    localparam logic [13:0] RAMP_FRAMES = 14'(P_RAMP_FRAMES);
    localparam logic [9:0] PWRUP_CYC = 10'(P_PWRUP_CYC);

    typedef struct packed {
        logic [1:0] f0_s;
        logic [1:0] f1_s;
        logic [1:0] dem_s;
        logic [7:0] mode1;
        logic [7:0] mode2;
        logic win_open;
        sdac_pkg::sdac_pwr_t pwr;
        logic [11:0] per_cnt;
        logic [11:0] per;
        logic [11:0] mck_cnt;
        logic [11:0] ratio;
        logic [13:0] frm_cnt;
        logic [9:0] cyc_cnt;
        logic [7:0] rdata;
        logic qref;
        logic bias;
        logic clamp;
        logic ramp;
        logic run;
        logic mute;
        sdac_pkg::sdac_speed_t speed;
        sdac_pkg::sdac_fmt_t fmt;
        sdac_pkg::sdac_deem_t deem;
        logic [23:0] left;
        logic [23:0] right;
        logic valid;
    } sdac_core_t;

    sdac_core_t s;
    sdac_core_t next_s;

    sdac_link_if lnk ();

    sdac_link_rx u_rx (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .master_clock_i(master_clock_i),
        .frame_clock_i(frame_clock_i),
        .bit_clock_i(bit_clock_i),
        .serial_sample_in_i(serial_sample_in_i),
        .lnk(lnk.rx)
    );

    assign lnk.fmt = s.fmt;

    // Frame period in core cycles to speed; out of range gives none
    function automatic sdac_pkg::sdac_speed_t speed_of(input logic [11:0] per);
        if (per >= SS_LO && per <= SS_HI) begin
            speed_of = sdac_pkg::SPD_SINGLE;
        end else if (per >= DS_LO && per <= DS_HI) begin
            speed_of = sdac_pkg::SPD_DOUBLE;
        end else if (per >= QS_LO && per <= QS_HI) begin
            speed_of = sdac_pkg::SPD_QUAD;
        end else begin
            speed_of = sdac_pkg::SPD_NONE;
        end
    endfunction : speed_of

    // Allowed master clocks per frame for each speed
    function automatic logic ratio_allowed(input sdac_pkg::sdac_speed_t spd,
                                           input logic [11:0] r);
        case (spd)
            sdac_pkg::SPD_SINGLE: ratio_allowed = r == 12'h100 || r == 12'h180
                || r == 12'h200 || r == 12'h300 || r == 12'h400 || r == 12'h480;
            sdac_pkg::SPD_DOUBLE: ratio_allowed = r == 12'h080 || r == 12'h0c0
                || r == 12'h100 || r == 12'h180 || r == 12'h200;
            sdac_pkg::SPD_QUAD: ratio_allowed = r == 12'h040 || r == 12'h060
                || r == 12'h080 || r == 12'h0c0 || r == 12'h100;
            default: ratio_allowed = 1'b0;
        endcase
    endfunction : ratio_allowed

    // Frames to wait after release, doubling per speed step
    function automatic logic [13:0] window_of(input sdac_pkg::sdac_speed_t spd);
        case (spd)
            sdac_pkg::SPD_DOUBLE: window_of = 14'(WIN_FRAMES << 1);
            sdac_pkg::SPD_QUAD: window_of = 14'(WIN_FRAMES << 2);
            default: window_of = WIN_FRAMES;
        endcase
    endfunction : window_of

    always_comb begin
        logic cp_mode;
        logic power_down_bit;
        logic trans;
        logic [11:0] mck_sum;
        logic [1:0] spd_sel;
        logic [2:0] reg_fmt;
        sdac_pkg::sdac_speed_t spd;
        sdac_pkg::sdac_pwr_t nxt;
        cp_mode = s.mode2[`SDAC_M2_CPEN_BIT];
        power_down_bit = s.mode2[`SDAC_M2_PDN_BIT];
        spd_sel = s.mode1[`SDAC_M1_SPEED_LSB +: 2];
        reg_fmt = s.mode2[`SDAC_M2_FMT_LSB +: 3];
        mck_sum = s.mck_cnt;
        spd = sdac_pkg::SPD_NONE;
        nxt = s.pwr;
        trans = 1'b0;
        next_s = s;

        // Configuration pins cross into the core clock first
        next_s.f0_s = {s.f0_s[0], format_sel_bit0_i};
        next_s.f1_s = {s.f1_s[0], format_sel_bit1_i};
        next_s.dem_s = {s.dem_s[0], deemph_pin_i};

        // Frame period and master clocks per frame
        if (s.per_cnt != 12'hfff) begin
            next_s.per_cnt = s.per_cnt + 12'h001;
        end
        if (lnk.mck_rise && s.mck_cnt != 12'hfff) begin
            mck_sum = s.mck_cnt + 12'h001;
        end
        next_s.mck_cnt = mck_sum;
        if (lnk.frm_rise) begin
            next_s.per = s.per_cnt;
            next_s.per_cnt = 12'h001;
            next_s.ratio = mck_sum;
            next_s.mck_cnt = 12'h000;
        end

        // Manual speed only through registers; pins always auto-detect
        if (cp_mode && spd_sel != 2'h0) begin
            spd = sdac_pkg::sdac_speed_t'(spd_sel);
        end else begin
            spd = speed_of(s.per);
        end
        next_s.speed = spd;

        // Register writes; defaults come back with reset
        if (reg_wr_i) begin
            if (reg_addr_i == `SDAC_ADDR_MODE1) begin
                next_s.mode1 = reg_wdata_i;
            end else if (reg_addr_i == `SDAC_ADDR_MODE2) begin
                next_s.mode2 = reg_wdata_i;
                // Port enable is only taken while the window is open
                next_s.mode2[`SDAC_M2_CPEN_BIT] = cp_mode | (reg_wdata_i[`SDAC_M2_CPEN_BIT] & s.win_open);
            end
        end

        next_s.rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == `SDAC_ADDR_MODE1) begin
                next_s.rdata = s.mode1;
            end else if (reg_addr_i == `SDAC_ADDR_MODE2) begin
                next_s.rdata = s.mode2;
            end else if (reg_addr_i == `SDAC_ADDR_STAT) begin
                next_s.rdata[`SDAC_ST_STATE_LSB +: 3] = s.pwr;
                next_s.rdata[`SDAC_ST_SPEED_LSB +: 2] = s.speed;
                next_s.rdata[`SDAC_ST_RATIO_BIT] = ~s.mute;
                next_s.rdata[`SDAC_ST_CPMODE_BIT] = cp_mode;
            end
        end

        // Format source: pins give four, registers six
        if (cp_mode) begin
            next_s.fmt = (reg_fmt > 3'h5) ? sdac_pkg::FMT_STD : sdac_pkg::sdac_fmt_t'(reg_fmt);
        end else begin
            next_s.fmt = sdac_pkg::sdac_fmt_t'({1'b0, s.f0_s[1], s.f1_s[1]});
        end

        // De-emphasis has no meaning above single speed
        if (spd != sdac_pkg::SPD_SINGLE) begin
            next_s.deem = sdac_pkg::DEM_OFF;
        end else if (cp_mode) begin
            next_s.deem = sdac_pkg::sdac_deem_t'(s.mode1[`SDAC_M1_DEEM_LSB +: 2]);
        end else begin
            next_s.deem = s.dem_s[1] ? sdac_pkg::DEM_441 : sdac_pkg::DEM_OFF;
        end

        // Pin mode always runs the transient sequence
        trans = cp_mode ? s.mode2[`SDAC_M2_TRANS_BIT] : 1'b1;

        case (s.pwr)
            sdac_pkg::PWR_WAIT: begin
                // Frames are only counted once a speed is known
                if (lnk.frm_rise && spd != sdac_pkg::SPD_NONE) begin
                    next_s.frm_cnt = s.frm_cnt + 14'h0001;
                end
                if (next_s.mode2[`SDAC_M2_CPEN_BIT]) begin
                    nxt = sdac_pkg::PWR_STBY;
                    next_s.win_open = 1'b0;
                end else if (s.frm_cnt >= window_of(spd) && spd != sdac_pkg::SPD_NONE) begin
                    nxt = sdac_pkg::PWR_UP;
                    next_s.win_open = 1'b0;
                end
            end
            sdac_pkg::PWR_STBY: begin
                if (!power_down_bit) begin
                    nxt = sdac_pkg::PWR_UP;
                end
            end
            sdac_pkg::PWR_UP: begin
                if (trans) begin
                    nxt = sdac_pkg::PWR_CLAMP;
                end else if (s.cyc_cnt >= PWRUP_CYC - 10'h001) begin
                    nxt = sdac_pkg::PWR_RUN;
                end else begin
                    next_s.cyc_cnt = s.cyc_cnt + 10'h001;
                end
            end
            sdac_pkg::PWR_CLAMP: begin
                if (lnk.frm_rise) begin
                    next_s.frm_cnt = s.frm_cnt + 14'h0001;
                end
                if (s.frm_cnt >= CLAMP_FRAMES) begin
                    nxt = sdac_pkg::PWR_RAMP;
                end
            end
            sdac_pkg::PWR_RAMP: begin
                if (lnk.frm_rise) begin
                    next_s.frm_cnt = s.frm_cnt + 14'h0001;
                end
                if (s.frm_cnt >= RAMP_FRAMES) begin
                    nxt = sdac_pkg::PWR_RUN;
                end
            end
            sdac_pkg::PWR_RUN: begin
                nxt = sdac_pkg::PWR_RUN;
            end
            default: begin
                nxt = sdac_pkg::PWR_WAIT;
            end
        endcase

        // Setting power-down again drops back to standby
        if (cp_mode && power_down_bit && s.pwr != sdac_pkg::PWR_WAIT) begin
            nxt = sdac_pkg::PWR_STBY;
        end
        if (nxt != s.pwr) begin
            next_s.frm_cnt = 14'h0000;
            next_s.cyc_cnt = 10'h000;
        end
        next_s.pwr = nxt;

        // Reference stays low and bias tied until power-up begins
        next_s.qref = nxt != sdac_pkg::PWR_WAIT && nxt != sdac_pkg::PWR_STBY;
        next_s.bias = ~next_s.qref;
        next_s.clamp = nxt != sdac_pkg::PWR_RAMP && nxt != sdac_pkg::PWR_RUN;
        next_s.ramp = nxt == sdac_pkg::PWR_RAMP;
        next_s.run = nxt == sdac_pkg::PWR_RUN;
        next_s.mute = ~(next_s.run && ratio_allowed(spd, s.ratio));

        // Samples pass only while running with good clocks
        next_s.valid = 1'b0;
        if (lnk.sample_valid && !next_s.mute) begin
            next_s.left = lnk.left;
            next_s.right = lnk.right;
            next_s.valid = 1'b1;
        end
    end

    // Reset puts every register at its default
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
            s.mode1 <= `SDAC_MODE1_RST;
            s.mode2 <= `SDAC_MODE2_RST;
            s.win_open <= 1'b1;
            s.pwr <= sdac_pkg::PWR_WAIT;
            s.bias <= 1'b1;
            s.clamp <= 1'b1;
            s.mute <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_o = s.rdata;
    assign quiescent_ref_o = s.qref;
    assign bias_node_tie_o = s.bias;
    assign out_clamp_o = s.clamp;
    assign out_ramp_o = s.ramp;
    assign audio_run_o = s.run;
    assign mute_o = s.mute;
    assign speed_o = s.speed;
    assign format_o = s.fmt;
    assign deemph_o = s.deem;
    assign sample_left_o = s.left;
    assign sample_right_o = s.right;
    assign sample_valid_o = s.valid;

endmodule : sdac_front
`default_nettype wire

// ===== tb/sdac_src_model.sv
// Audio source model: clocks and left-justified or standard stereo words
`timescale 1ns/100ps
`default_nettype none
module sdac_src_model (
    input wire logic [47:0] word_i,
    input wire logic std_fmt_i,
    output logic master_clock_o,
    output logic frame_clock_o,
    output logic bit_clock_o,
    output logic serial_sample_o,
    output logic [47:0] sent_o
);
    logic [47:0] w;
    logic st;
    int k;
    initial begin
        {master_clock_o, frame_clock_o, bit_clock_o, serial_sample_o, sent_o} = '0;
        #37;
        forever begin
            w = word_i;
            // Format held per frame, so a switch never splits one
            st = std_fmt_i;
            // 128 bit clocks, 256 master clocks a frame
            for (int b = 0; b < 128; b++) begin
                // Standard stereo: left while frame low, one bit late
                {bit_clock_o, master_clock_o, frame_clock_o} = {2'h1, (b < 64) ^ st};
                k = b % 64 - int'(st);
                // Idle slots toggle, never a held bit
                serial_sample_o = k >= 0 && k < 24 ? w[47 - 24 * (b / 64) - k] : b[0];
                #200 master_clock_o = 1'b0;
                #200 {bit_clock_o, master_clock_o} = 2'h3;
                #200 master_clock_o = 1'b0;
                #200;
            end
            sent_o = w;
        end
    end
endmodule : sdac_src_model
`default_nettype wire

// ===== tb/sdac_front_properties.sv
// Port assertions of the converter front end
`timescale 1ns/100ps
`default_nettype none
module sdac_front_chk (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic quiescent_ref_o,
    input wire logic bias_node_tie_o,
    input wire logic out_clamp_o,
    input wire logic out_ramp_o,
    input wire logic audio_run_o,
    input wire logic mute_o,
    input wire logic [1:0] speed_o,
    input wire logic [2:0] format_o,
    input wire logic [1:0] deemph_o,
    input wire logic sample_valid_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    bias_tie_a: assert property (bias_node_tie_o != quiescent_ref_o) else $error("bias tie");
    low_clamp_a: assert property (!quiescent_ref_o |-> out_clamp_o) else $error("no clamp");
    fmt_range_a: assert property (format_o <= 3'h5) else $error("bad format");
    deem_single_a: assert property (speed_o != 2'h1 [*2] |-> deemph_o == 2'h0) else $error("deem");
    run_clean_a: assert property (audio_run_o |-> !out_clamp_o && !out_ramp_o) else $error("run");
    ramp_order_a: assert property ($rose(out_ramp_o) |-> $past(out_clamp_o)) else $error("ramp");
    run_mute_a: assert property (!audio_run_o |-> mute_o) else $error("mute off");
    valid_pulse_a: assert property (sample_valid_o |=> !sample_valid_o) else $error("valid");
    pwr_order_a: assert property ($rose(audio_run_o) |-> $past(quiescent_ref_o, 2)) else $error("early");
    cover property ($rose(audio_run_o));
    cover property ($rose(out_ramp_o));
    cover property (sample_valid_o);
endmodule : sdac_front_chk
bind sdac_front sdac_front_chk chk (.*);
`default_nettype wire

// ===== tb/sdac_front_tb.sv
// Self-checking bench of the converter front end
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module sdac_front_tb;
    logic core_clk_i = 0, rst_b_i = 0, format_sel_bit0_i = 0, format_sel_bit1_i = 1, deemph_pin_i = 1;
    logic reg_wr_i = 0, reg_rd_i = 0, master_clock_i, frame_clock_i, bit_clock_i, serial_sample_in_i;
    logic quiescent_ref_o, bias_node_tie_o, out_clamp_o, out_ramp_o, audio_run_o, mute_o, sample_valid_o;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
    logic [1:0] speed_o, deemph_o;
    logic [2:0] format_o;
    logic [23:0] sample_left_o, sample_right_o;
    logic [47:0] word = 0, sent, q[$];
    logic std_fmt = 0;
    integer seed = 6109, error_cnt = 0, check_count = 0, n;
    sdac_front #(.P_WIN_FRAMES(4), .P_CLAMP_FRAMES(4), .P_RAMP_FRAMES(8), .P_PWRUP_CYC(10)) DUT (.*);
    sdac_src_model src (.word_i(word), .std_fmt_i(std_fmt), .master_clock_o(master_clock_i), .frame_clock_o(frame_clock_i),
        .bit_clock_o(bit_clock_i), .serial_sample_o(serial_sample_in_i), .sent_o(sent));
    always #50 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) word <= 48'({$random(seed), $random(seed)});
    always @(sent) q.push_back(sent);
    always @(negedge core_clk_i) if (sample_valid_o === 1'b1) begin
        `CHK("pair", q[$], {sample_left_o, sample_right_o})
        q.delete();
    end
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk_i);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        cyc(3);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge core_clk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK("rdata", e, reg_rdata_o & m)
    endtask : rd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic wait_run(input int lim);
        for (n = 0; audio_run_o !== 1'b1 && n < lim; n++) @(posedge core_clk_i);
        if (n >= lim) begin
            `CHK("run", 1'b1, audio_run_o)
            wrap_up();
        end
        #1;
    endtask : wait_run
    task automatic do_reset();
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        cyc(1);
    endtask : do_reset
    initial begin
        do_reset();
        cyc(2500);
        `CHK("qref", 1'b0, quiescent_ref_o)
        `CHK("bias", 1'b1, bias_node_tie_o)
        `CHK("deem", 2'h2, deemph_o)
        // Ends on left-justified, the format the source sends
        for (int c = 0; c < 4; c++) begin
            @(posedge core_clk_i);
            {format_sel_bit0_i, format_sel_bit1_i} <= {!c[1], c[0]};
            cyc(8);
            `CHK("fmt", 3'(c ^ 2), format_o)
        end
        wait_run(40000);
        `CHK("qref", 1'b1, quiescent_ref_o)
        `CHK("mute", 1'b0, mute_o)
        cyc(4000);
        $display("pin mode test done");
        do_reset();
        rd(8'h01, 8'h00, 8'hff);
        rd(8'h02, 8'h80, 8'hff);
        wr(8'h09, 8'h5a);
        rd(8'h09, 8'h00, 8'hff);
        wr(8'h02, 8'hc1);
        wr(8'h02, 8'h81);
        rd(8'h02, 8'hc1, 8'hff);
        rd(8'h03, 8'h44, 8'h47);
        for (int f = 0; f < 8; f++) begin
            wr(8'h02, 8'hc0 | 8'(f));
            `CHK("fmt", 3'(f > 5 ? 0 : f), format_o)
        end
        for (int i = 1; i < 7; i++) begin
            wr(8'h01, 8'(i < 4 ? i * 4 + 1 : i + 9));
            `CHK("speed", i < 4 ? 2'h1 : 2'(i - 3), speed_o)
            `CHK("deem", i < 4 ? 2'(i) : i == 4 ? 2'h3 : 2'h0, deemph_o)
        end
        wr(8'h01, 8'h00);
        // Standard stereo run; whole frames pass before unmuting
        std_fmt <= 1'b1;
        cyc(2100);
        wr(8'h02, 8'h00);
        `CHK("run", 1'b0, audio_run_o)
        wait_run(20);
        rd(8'h03, 8'h6e, 8'hff);
        cyc(4000);
        wr(8'h02, 8'h81);
        `CHK("run", 1'b0, audio_run_o)
        rd(8'h03, 8'h04, 8'h07);
        $display("register mode test done");
        wrap_up();
    end
endmodule : sdac_front_tb
`default_nettype wire
